// File: hdl/cecrx_pkg.sv
// Overview of operation
// - Reject start bit longer than 154+adj.
// - Reject start bit shorter than 141-adj.
// - Reject start rise later than 128+adj.
// - Reject start rise earlier than 115-adj.
// - Zero bit without rise by 56+adj errs.
// - Zero bit earliest rise is 43-adj.
// - One bit latest rise is 26+adj.
// - Shape windows apply only when check enabled.
// - Rise between one-late and zero-early errs.
// - Rise before 13-adj is an error.
package cecrx_pkg;
	localparam logic [4:0] OFS_START = 5'h00;
	localparam logic [4:0] OFS_SHAPE = 5'h04;
	localparam logic [4:0] OFS_CTRL  = 5'h08;
	localparam logic [4:0] OFS_STAT  = 5'h0c;
	localparam logic [4:0] OFS_MASK  = 5'h10;
	localparam logic [31:0] START_RMASK = 32'h0000_7777;
	localparam logic [31:0] SHAPE_RMASK = 32'h0077_7701;
	localparam int PMAX_LSB = 12;
	localparam int PMIN_LSB = 8;
	localparam int RLAT_LSB = 4;
	localparam int REAR_LSB = 0;
	localparam int ZLAT_LSB = 20;
	localparam int ZEAR_LSB = 16;
	localparam int OLAT_LSB = 12;
	localparam int OEAR_LSB = 8;
	localparam int CHK_BIT  = 0;
	localparam logic [8:0] START_PMAX = 9'd154;
	localparam logic [8:0] START_PMIN = 9'd141;
	localparam logic [8:0] START_RLAT = 9'd128;
	localparam logic [8:0] START_REAR = 9'd115;
	localparam logic [8:0] ZERO_LAT   = 9'd56;
	localparam logic [8:0] ZERO_EAR   = 9'd43;
	localparam logic [8:0] ONE_LAT    = 9'd26;
	localparam logic [8:0] ONE_EAR    = 9'd13;
	localparam logic [8:0] CNT_MAX    = 9'h1ff;
	localparam int EV_START = 0;
	localparam int EV_SERR  = 1;
	localparam int EV_WERR  = 2;
	localparam int EV_BIT   = 3;
	typedef struct packed {
		logic [4:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cecrx_bus_t;
	typedef struct packed {
		logic valid;
		logic value;
	} cecrx_bit_t;
endpackage

// File: hdl/cecrx_checker.sv
`timescale 1ns/1ps
module cecrx_checker #(
	parameter int ADJ_W = 3
) (
	// Clock, reset, enable
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	// Sample strobe (fs tick, same domain)
	input  wire logic              fs_tick,
	// Line pin
	input  wire logic              cec_in,
	// Register port
	input  wire cecrx_pkg::cecrx_bus_t bus,
	output logic [31:0]            rdata,
	// Results
	output cecrx_pkg::cecrx_bit_t  bit_out,
	output logic                   start_seen,
	output logic                   irq
);
	// The window fields are three bits wide in both registers
	if (ADJ_W != 3) begin : g_bad_adj_w
		$error("ADJ_W must be 3");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA} cecrx_state_t;

	logic [31:0]  start_reg, start_next;
	logic [31:0]  shape_reg, shape_next;
	logic         ren_reg;
	logic [3:0]   stat_reg, mask_reg;
	logic [31:0]  rdata_reg;
	logic         irq_reg;
	logic [2:0]   sync_reg;
	logic [8:0]   cnt_reg;
	logic         rose_reg;
	logic         bad_reg;
	logic         val_reg;
	cecrx_state_t state_reg;
	cecrx_pkg::cecrx_bit_t bit_reg;
	logic         start_ev_reg;

	function automatic logic [8:0] fld(input logic [31:0] r, input int lsb);
		fld = {6'h00, r[lsb +: 3]};
	endfunction

	wire line_fall = sync_reg[2] & ~sync_reg[1];
	wire line_rise = ~sync_reg[2] & sync_reg[1];
	wire tick      = clk_en & fs_tick;
	wire chk_en    = shape_reg[cecrx_pkg::CHK_BIT];

	// Window limits
	wire [8:0] s_pmax = cecrx_pkg::START_PMAX
		+ fld(start_reg, cecrx_pkg::PMAX_LSB);
	wire [8:0] s_pmin = cecrx_pkg::START_PMIN
		- fld(start_reg, cecrx_pkg::PMIN_LSB);
	wire [8:0] s_rlat = cecrx_pkg::START_RLAT
		+ fld(start_reg, cecrx_pkg::RLAT_LSB);
	wire [8:0] s_rear = cecrx_pkg::START_REAR
		- fld(start_reg, cecrx_pkg::REAR_LSB);
	wire [8:0] z_lat  = cecrx_pkg::ZERO_LAT
		+ fld(shape_reg, cecrx_pkg::ZLAT_LSB);
	wire [8:0] z_ear  = cecrx_pkg::ZERO_EAR
		- fld(shape_reg, cecrx_pkg::ZEAR_LSB);
	wire [8:0] o_lat  = cecrx_pkg::ONE_LAT
		+ fld(shape_reg, cecrx_pkg::OLAT_LSB);
	wire [8:0] o_ear  = cecrx_pkg::ONE_EAR
		- fld(shape_reg, cecrx_pkg::OEAR_LSB);

	// Data-bit rise classification
	wire rise_early = cnt_reg < o_ear;
	wire rise_gap   = (cnt_reg > o_lat) && (cnt_reg < z_ear);
	wire rise_late  = cnt_reg > z_lat;
	wire rise_bad   = chk_en & (rise_early | rise_gap | rise_late);
	wire rise_zero  = cnt_reg >= z_ear;
	// Zero bit that never rose in time
	wire zero_timeout = chk_en & ~rose_reg & (cnt_reg > z_lat);

	// Start-bit checks at rise and at end of period
	wire s_rise_ok  = (cnt_reg >= s_rear) && (cnt_reg <= s_rlat);
	wire s_per_ok   = (cnt_reg >= s_pmin) && (cnt_reg <= s_pmax);
	wire s_overrun  = cnt_reg > s_pmax;

	// Register decode
	wire wr_start = bus.wr && bus.addr == cecrx_pkg::OFS_START;
	wire wr_shape = bus.wr && bus.addr == cecrx_pkg::OFS_SHAPE;
	wire wr_ctrl  = bus.wr && bus.addr == cecrx_pkg::OFS_CTRL;
	wire wr_stat  = bus.wr && bus.addr == cecrx_pkg::OFS_STAT;
	wire wr_mask  = bus.wr && bus.addr == cecrx_pkg::OFS_MASK;
	wire [31:0] rd_mux =
		(bus.addr == cecrx_pkg::OFS_START) ? start_reg :
		(bus.addr == cecrx_pkg::OFS_SHAPE) ? shape_reg :
		(bus.addr == cecrx_pkg::OFS_CTRL)  ? {31'h0, ren_reg} :
		(bus.addr == cecrx_pkg::OFS_STAT)  ? {28'h0, stat_reg} :
		(bus.addr == cecrx_pkg::OFS_MASK)  ? {28'h0, mask_reg} :
		32'h0;

	assign start_next = bus.wdata & cecrx_pkg::START_RMASK;
	assign shape_next = bus.wdata & cecrx_pkg::SHAPE_RMASK;

	// Event pulses produced by the bit engine this cycle
	logic [3:0] ev;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			start_reg <= 32'h0;
			shape_reg <= 32'h0;
			ren_reg   <= 1'b0;
			mask_reg  <= 4'h0;
			stat_reg  <= 4'h0;
			rdata_reg <= 32'h0;
			irq_reg   <= 1'b0;
		end else if (clk_en) begin
			// Timing writes are trusted only with reception stopped
			if (wr_start) start_reg <= start_next;
			if (wr_shape) shape_reg <= shape_next;
			if (wr_ctrl)  ren_reg   <= bus.wdata[0];
			if (wr_mask)  mask_reg  <= bus.wdata[3:0];
			// Set wins over write-one-to-clear
			stat_reg  <= (stat_reg & ~(wr_stat ? bus.wdata[3:0] : 4'h0)) | ev;
			rdata_reg <= bus.rd ? rd_mux : 32'h0;
			irq_reg   <= |(((stat_reg & ~(wr_stat ? bus.wdata[3:0] : 4'h0))
				| ev) & mask_reg);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync_reg     <= 3'h7;
			cnt_reg      <= 9'h0;
			rose_reg     <= 1'b0;
			bad_reg      <= 1'b0;
			val_reg      <= 1'b0;
			state_reg    <= ST_IDLE;
			bit_reg      <= '0;
			start_ev_reg <= 1'b0;
			ev           <= 4'h0;
		end else if (clk_en) begin
			sync_reg     <= {sync_reg[1:0], cec_in};
			ev           <= 4'h0;
			bit_reg.valid <= 1'b0;
			start_ev_reg <= 1'b0;
			if (tick && cnt_reg != cecrx_pkg::CNT_MAX)
				cnt_reg <= cnt_reg + 9'd1;
			case (state_reg)
			ST_IDLE: begin
				if (ren_reg && line_fall) begin
					cnt_reg   <= 9'h0;
					rose_reg  <= 1'b0;
					bad_reg   <= 1'b0;
					state_reg <= ST_START;
				end
			end
			ST_START: begin
				if (!ren_reg) begin
					state_reg <= ST_IDLE;
				end else if (line_rise && !rose_reg) begin
					rose_reg <= 1'b1;
					bad_reg  <= ~s_rise_ok;
				end else if (line_fall) begin
					cnt_reg  <= 9'h0;
					rose_reg <= 1'b0;
					bad_reg  <= 1'b0;
					if (rose_reg && !bad_reg && s_per_ok) begin
						ev[cecrx_pkg::EV_START] <= 1'b1;
						start_ev_reg <= 1'b1;
						state_reg <= ST_DATA;
					end else begin
						ev[cecrx_pkg::EV_SERR] <= 1'b1;
					end
				end else if (s_overrun) begin
					ev[cecrx_pkg::EV_SERR] <= 1'b1;
					state_reg <= ST_IDLE;
				end
			end
			ST_DATA: begin
				if (!ren_reg) begin
					state_reg <= ST_IDLE;
				end else if (line_rise && !rose_reg) begin
					rose_reg <= 1'b1;
					val_reg  <= ~rise_zero;
					if (rise_bad)
						ev[cecrx_pkg::EV_WERR] <= 1'b1;
					else begin
						bit_reg.valid <= 1'b1;
						bit_reg.value <= ~rise_zero;
						ev[cecrx_pkg::EV_BIT] <= 1'b1;
					end
				end else if (zero_timeout && !bad_reg) begin
					bad_reg <= 1'b1;
					ev[cecrx_pkg::EV_WERR] <= 1'b1;
				end else if (line_fall) begin
					cnt_reg  <= 9'h0;
					rose_reg <= 1'b0;
					bad_reg  <= 1'b0;
				end else if (cnt_reg == cecrx_pkg::CNT_MAX) begin
					state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign rdata      = rdata_reg;
	assign bit_out    = bit_reg;
	assign start_seen = start_ev_reg;
	assign irq        = irq_reg;
endmodule

// File: tb/cecrx_checker_properties.sv
`timescale 1ns/1ps
module cecrx_props (
	// Clock and control
	input wire logic                  sys_clk,
	input wire logic                  rst_n,
	input wire logic                  clk_en,
	input wire logic                  fs_tick,
	input wire logic                  cec_in,
	// Register port
	input wire cecrx_pkg::cecrx_bus_t bus,
	input wire logic [31:0]           rdata,
	// Results
	input wire cecrx_pkg::cecrx_bit_t bit_out,
	input wire logic                  start_seen,
	input wire logic                  irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_idle; !bus.rd |=> rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata off");
	property p_rs;
		bus.rd && bus.addr == cecrx_pkg::OFS_START
		|=> (rdata & ~cecrx_pkg::START_RMASK) == 32'h0;
	endproperty
	a_rs: assert property (p_rs) else $error("start rsv");
	property p_rw;
		bus.rd && bus.addr == cecrx_pkg::OFS_SHAPE
		|=> (rdata & ~cecrx_pkg::SHAPE_RMASK) == 32'h0;
	endproperty
	a_rw: assert property (p_rw) else $error("shape rsv");
	property p_un; bus.rd && bus.addr == 4'h2 |=> rdata == 32'h0; endproperty
	a_un: assert property (p_un) else $error("unmapped");
	property p_sp; start_seen |=> !start_seen; endproperty
	a_sp: assert property (p_sp) else $error("start pulse");
	property p_bp; bit_out.valid |=> !bit_out.valid; endproperty
	a_bp: assert property (p_bp) else $error("bit pulse");
	property p_ex; start_seen |-> !bit_out.valid; endproperty
	a_ex: assert property (p_ex) else $error("both");
	property p_fz; !clk_en |=> $stable(irq); endproperty
	a_fz: assert property (p_fz) else $error("frozen");
	c_st: cover property (start_seen);
	c_bt: cover property (bit_out.valid);
	c_rd: cover property (bus.rd ##1 rdata != 32'h0);
endmodule
bind cecrx_checker cecrx_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
	.clk_en(clk_en), .fs_tick(fs_tick), .cec_in(cec_in), .bus(bus),
	.rdata(rdata), .bit_out(bit_out), .start_seen(start_seen), .irq(irq));

// File: tb/cecrx_line.sv
`timescale 1ns/1ps
module cecrx_line (
	// Shared line, pulled up when idle
	output logic cec_in
);
	initial cec_in = 1'b1;
	// One bit: low for rise ticks, released until per ticks; tick is 16 ns
	task automatic send(input int rise, input int per);
		cec_in = 1'b0;
		#(rise * 16);
		cec_in = 1'b1;
		#((per - rise) * 16);
	endtask
endmodule

// File: tb/test_cec_rx_timing_checker.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_cec_rx_timing_checker;
	logic sys_clk, rst_n, clk_en, fs_tick, cec_in, irq, start_seen;
	logic [31:0] rdata, d, v;
	cecrx_pkg::cecrx_bus_t bus;
	cecrx_pkg::cecrx_bit_t bit_out;
	int errors, n_checks, n_start, n0, cyc, a;
	logic bq[$];
	int rs[5], ps[5], es[5], en[4], wr_r[4], wp[4], we[4];
	cecrx_line u_line (.cec_in(cec_in));
	cecrx_checker u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.fs_tick(fs_tick), .cec_in(cec_in), .bus(bus), .rdata(rdata),
		.bit_out(bit_out), .start_seen(start_seen), .irq(irq));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		fs_tick <= ~fs_tick;
		cyc++;
		if (start_seen === 1'b1) n_start++;
		if (bit_out.valid === 1'b1) bq.push_back(bit_out.value);
		if (cyc == 60000) begin
			errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] wd);
		bus.addr <= ad;
		bus.wdata <= wd;
		bus.wr <= 1'b1;
		@(posedge sys_clk);
		bus.wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Stop reception and confirm it before touching any window field
	task automatic rx_off();
		wr(cecrx_pkg::OFS_CTRL, 32'h0);
		rd(cecrx_pkg::OFS_CTRL, d);
		`CHK(d[0], 1'b0)
	endtask
	task automatic rd(input logic [4:0] ad, output logic [31:0] q);
		bus.addr <= ad;
		bus.rd <= 1'b1;
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 q = rdata;
		@(posedge sys_clk);
	endtask
	initial begin
		{errors, n_checks, n_start, cyc} = '0;
		{rst_n, fs_tick, clk_en, bus} = '0;
		void'($urandom(32'h8282));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		clk_en <= 1'b1;
		@(posedge sys_clk);
		rd(cecrx_pkg::OFS_START, d);
		`CHK(d, 32'h0)
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			wr(cecrx_pkg::OFS_START, v);
			rd(cecrx_pkg::OFS_START, d);
			`CHK(d, v & cecrx_pkg::START_RMASK)
			wr(cecrx_pkg::OFS_SHAPE, v);
			rd(cecrx_pkg::OFS_SHAPE, d);
			`CHK(d, v & cecrx_pkg::SHAPE_RMASK)
			rd(4'h2, d);
			`CHK(d, 32'h0)
		end
		clk_en <= 1'b0;
		@(posedge sys_clk);
		clk_en <= 1'b1;
		a = $urandom % 8;
		wr(cecrx_pkg::OFS_CTRL, 32'h0);
		rd(cecrx_pkg::OFS_CTRL, d);
		`CHK(d[0], 1'b0)
		wr(cecrx_pkg::OFS_START, a * 32'h1111);
		wr(cecrx_pkg::OFS_SHAPE, 32'h0);
		wr(cecrx_pkg::OFS_CTRL, 32'h1);
		rs = '{122, 132 + a, 111 - a, 122, 122};
		ps = '{148, 152 + a, 148, 137 - a, 158 + a};
		es = '{1, 0, 0, 0, 0};
		for (int i = 0; i < 5; i++) begin
			rx_off();
			wr(cecrx_pkg::OFS_CTRL, 32'h1);
			n0 = n_start;
			u_line.send(rs[i], ps[i]);
			u_line.send(20, 48);
			repeat (10) @(posedge sys_clk);
			`CHK(n_start - n0, es[i])
		end
		rx_off();
		wr(cecrx_pkg::OFS_CTRL, 32'h1);
		bq.delete();
		u_line.send(122, 148);
		u_line.send(20, 48);
		u_line.send(50, 60);
		u_line.send(20, 48);
		repeat (10) @(posedge sys_clk);
		`CHK(bq.size() >= 2 ? {bq[0], bq[1]} : 2'bxx, 2'b10)
		en = '{1, 1, 0, 1};
		wr_r = '{30, 8, 30, 64};
		wp = '{48, 48, 48, 72};
		we = '{1, 1, 0, 1};
		wr(cecrx_pkg::OFS_MASK, 32'h1 << cecrx_pkg::EV_WERR);
		rd(cecrx_pkg::OFS_MASK, d);
		`CHK(d, 32'h4)
		for (int i = 0; i < 4; i++) begin
			rx_off();
			wr(cecrx_pkg::OFS_SHAPE, en[i]);
			wr(cecrx_pkg::OFS_STAT, 32'hf);
			wr(cecrx_pkg::OFS_CTRL, 32'h1);
			u_line.send(122, 148);
			u_line.send(wr_r[i], wp[i]);
			u_line.send(20, 48);
			repeat (10) @(posedge sys_clk);
			rd(cecrx_pkg::OFS_STAT, d);
			`CHK(d[cecrx_pkg::EV_WERR], we[i][0])
		end
		`CHK(irq, 1'b1)
		wr(cecrx_pkg::OFS_STAT, 32'hf);
		rd(cecrx_pkg::OFS_STAT, d);
		`CHK(d[cecrx_pkg::EV_WERR], 1'b0)
		`CHK(irq, 1'b0)
		end_sim();
	end
endmodule
